// [core/i2c_mode_ctrl.sv]
// APB registers, request handshake and two-wire bit engine
`timescale 1ns/100ps
`include "i2c_mode_regs.svh"
module i2c_mode_and_recovery_control (
  input  wire logic        clk,
  input  wire logic        rst_n,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        link_clk,
  input  wire logic        scl_in,
  output logic             scl_out,
  output logic             scl_oe_n,
  input  wire logic        sda_in,
  output logic             sda_out,
  output logic             sda_oe_n
);

  ////////////////////////////////////////////////////////////////////////////////
  // System clock side

  logic        ctl_reset;
  logic        order;
  logic        wait_en;
  logic [2:0]  bit_count;
  logic        format_sync;
  logic [6:0]  slave_addr;
  logic        busy;
  logic        req_tgl;
  logic        done_seen;
  logic        done_s;
  logic        mon;
  logic [7:0]  rx_data;
  logic        ack_in;
  logic [7:0]  cmd_data;
  logic        cmd_start;
  logic        cmd_stop;
  logic        cmd_recv;
  logic        cmd_master;
  logic        cmd_ack;
  logic        cmd_order;
  logic        cmd_wait;
  logic        cmd_format;
  logic [2:0]  cmd_count;
  logic [7:0]  ctrl_word;
  logic [7:0]  bm_word;
  logic [31:0] rd_word;
  logic        hit;
  logic        wr;
  logic        done_ev;
  logic        done_tgl;
  logic [7:0]  rx_hold;
  logic        ack_rx;
  logic        scl_level;

  assign pready  = 1'b1;
  assign pslverr = psel && penable && !hit;
  assign wr      = psel && penable && pwrite && hit;
  assign done_ev = done_s != done_seen;

  always_comb begin
    ctrl_word                    = `CT_FIXED_ONES;
    ctrl_word[`CT_MON_BIT]       = mon;
    ctrl_word[`CT_RST_BIT]       = ctl_reset;
    bm_word                      = `BM_FIXED_ONES;
    bm_word[`BM_ORDER_BIT]       = order;
    bm_word[`BM_WAIT_BIT]        = wait_en;
    bm_word[`BM_COUNT_LSB +: 3]  = bit_count;
  end

  always_comb begin
    hit     = 1'b1;
    rd_word = 32'h0;
    case (paddr)
      `OFS_CTRL_TWO: rd_word[7:0] = ctrl_word;
      `OFS_BUS_MODE: rd_word[7:0] = bm_word;
      `OFS_SLV_ADDR: begin
        rd_word[`SA_ADDR_LSB +: 7] = slave_addr;
        rd_word[`SA_FORMAT_BIT]    = format_sync;
      end
      `OFS_XFER: begin
        rd_word[`XF_DATA_LSB +: 8] = rx_data;
        rd_word[`XF_BUSY_BIT]      = busy;
        rd_word[`XF_ACKIN_BIT]     = ack_in;
      end
      default: hit = 1'b0;
    endcase
  end

  // Read data is latched in the setup cycle so the access cycle answers at once
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      prdata <= 32'h0;
    end else if (psel && !penable && !pwrite) begin
      prdata <= rd_word;
    end
  end

  // Only writable fields are stored; fixed and monitor bits have no storage
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ctl_reset   <= `RST_CTRL_RESET;
      order       <= `RST_ORDER;
      wait_en     <= `RST_WAIT;
      bit_count   <= `RST_COUNT;
      format_sync <= `RST_FORMAT;
      slave_addr  <= `RST_SLV_ADDR;
    end else if (wr) begin
      if (paddr == `OFS_CTRL_TWO) begin
        ctl_reset <= pwdata[`CT_RST_BIT];
      end
      if (paddr == `OFS_BUS_MODE) begin
        order     <= pwdata[`BM_ORDER_BIT];
        wait_en   <= pwdata[`BM_WAIT_BIT];
        bit_count <= pwdata[`BM_COUNT_LSB +: 3];
      end
      if (paddr == `OFS_SLV_ADDR) begin
        format_sync <= pwdata[`SA_FORMAT_BIT];
        slave_addr  <= pwdata[`SA_ADDR_LSB +: 7];
      end
    end
  end

  // Command fields stay frozen while busy, so the link side may read them directly
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      busy       <= 1'b0;
      req_tgl    <= 1'b0;
      done_seen  <= 1'b0;
      rx_data    <= 8'h00;
      ack_in     <= 1'b0;
      cmd_data   <= 8'h00;
      cmd_start  <= 1'b0;
      cmd_stop   <= 1'b0;
      cmd_recv   <= 1'b0;
      cmd_master <= 1'b0;
      cmd_ack    <= 1'b0;
      cmd_order  <= 1'b0;
      cmd_wait   <= 1'b0;
      cmd_format <= 1'b0;
      cmd_count  <= 3'h0;
    end else begin
      done_seen <= done_s;
      if (ctl_reset) begin
        busy <= 1'b0;
      end else if (done_ev) begin
        busy    <= 1'b0;
        rx_data <= rx_hold;
        ack_in  <= ack_rx;
      end else if (wr && paddr == `OFS_XFER && !busy) begin
        busy       <= 1'b1;
        req_tgl    <= !req_tgl;
        cmd_data   <= pwdata[`XF_DATA_LSB +: 8];
        cmd_start  <= pwdata[`XF_START_BIT];
        cmd_stop   <= pwdata[`XF_STOP_BIT];
        cmd_recv   <= pwdata[`XF_RECV_BIT];
        cmd_master <= pwdata[`XF_MASTER_BIT];
        cmd_ack    <= pwdata[`XF_ACK_BIT];
        cmd_order  <= order;
        cmd_wait   <= wait_en;
        cmd_format <= format_sync;
        cmd_count  <= bit_count;
      end
    end
  end

  level_sync u_done (.clk(clk), .rst_n(rst_n), .d(done_tgl), .q(done_s));
  // Released-level reset, so the monitor reads high straight after reset
  level_sync #(.RST_VAL(1'b1)) u_mon (.clk(clk), .rst_n(rst_n), .d(scl_level), .q(mon));

  ////////////////////////////////////////////////////////////////////////////////
  // Link clock side

  logic                    req_s;
  logic                    rst_s;
  logic                    scl_s;
  logic                    sda_s;
  logic                    scl_d;
  logic                    req_seen;
  i2c_mode_pkg::eng_state_t state;
  logic [1:0]              phase;
  logic                    wrap;
  logic [3:0]              bit_idx;
  logic [3:0]              nbits;
  logic [7:0]              shreg;
  logic [7:0]              rxsh;
  logic                    sda_level;
  logic                    next_scl;
  logic [2:0]              wait_cnt;
  logic                    eff_wait;
  logic                    run;
  logic                    accept;
  logic                    drv;
  logic                    smp;
  logic                    fin;
  logic                    last_bit;

  level_sync u_req (.clk(link_clk), .rst_n(rst_n), .d(req_tgl), .q(req_s));
  level_sync u_rst (.clk(link_clk), .rst_n(rst_n), .d(ctl_reset), .q(rst_s));
  // Idle bus is high; a low reset value would show a false edge after reset
  level_sync #(.RST_VAL(1'b1)) u_scl (.clk(link_clk), .rst_n(rst_n), .d(scl_in), .q(scl_s));
  level_sync #(.RST_VAL(1'b1)) u_sda (.clk(link_clk), .rst_n(rst_n), .d(sda_in), .q(sda_s));

  phase_gen u_phase (.clk(link_clk), .rst_n(rst_n), .run(run), .phase(phase), .wrap(wrap));

  assign eff_wait = cmd_wait && cmd_master && !cmd_format;
  assign run      = cmd_master && (state != i2c_mode_pkg::ST_IDLE);
  assign accept   = (state == i2c_mode_pkg::ST_IDLE) && (req_s != req_seen);
  // As slave the bit timing follows the far master's SCL edges
  assign drv      = cmd_master ? (phase == `PH_DRIVE) : (scl_d && !scl_s);
  // Master samples in the last high phase: the wire synchroniser lags by two cycles
  assign smp      = cmd_master ? (phase == `PH_LAST) : (scl_s && !scl_d);
  assign fin      = cmd_master ? wrap : (scl_s && !scl_d);
  assign last_bit = bit_idx == (nbits - 4'h1);

  assign scl_out  = 1'b0;
  assign sda_out  = 1'b0;
  assign scl_oe_n = scl_level;
  assign sda_oe_n = sda_level;

  always_ff @(posedge link_clk or negedge rst_n) begin
    if (!rst_n) begin
      scl_d <= 1'b1;
    end else begin
      scl_d <= scl_s;
    end
  end

  // SCL is low in phases 0 and 1 and high in 2 and 3 of each transfer clock
  always_comb begin
    next_scl = 1'b1;
    if (cmd_master && state != i2c_mode_pkg::ST_IDLE) begin
      unique case (state)
        i2c_mode_pkg::ST_START: next_scl = phase != `PH_LAST;
        // A frame that ends without a stop leaves SCL high, so no stray clock follows
        i2c_mode_pkg::ST_BIT:   next_scl = (phase == 2'h1) || (phase == `PH_SAMPLE)
                                           || (phase == `PH_LAST && last_bit && cmd_format);
        i2c_mode_pkg::ST_ACK:   next_scl = (phase == 2'h1) || (phase == `PH_SAMPLE)
                                           || (phase == `PH_LAST && !cmd_stop);
        i2c_mode_pkg::ST_WAIT:  next_scl = 1'b0;
        i2c_mode_pkg::ST_STOP:  next_scl = phase != `PH_DRIVE;
        i2c_mode_pkg::ST_DONE:  next_scl = 1'b1;
        i2c_mode_pkg::ST_IDLE:  next_scl = 1'b1;
      endcase
    end
  end

  always_ff @(posedge link_clk or negedge rst_n) begin
    if (!rst_n) begin
      scl_level <= 1'b1;
    end else if (rst_s) begin
      scl_level <= 1'b1;
    end else begin
      scl_level <= next_scl;
    end
  end

  always_ff @(posedge link_clk or negedge rst_n) begin
    if (!rst_n) begin
      state     <= i2c_mode_pkg::ST_IDLE;
      req_seen  <= 1'b0;
      done_tgl  <= 1'b0;
      bit_idx   <= 4'h0;
      nbits     <= `FIRST_FRAME_BITS;
      shreg     <= 8'h00;
      rxsh      <= 8'h00;
      rx_hold   <= 8'h00;
      ack_rx    <= 1'b0;
      sda_level <= 1'b1;
      wait_cnt  <= 3'h0;
    end else if (rst_s) begin
      // Absorbs any pending request so release does not start a stale transfer
      state     <= i2c_mode_pkg::ST_IDLE;
      req_seen  <= req_s;
      sda_level <= 1'b1;
      bit_idx   <= 4'h0;
      wait_cnt  <= 3'h0;
    end else begin
      unique case (state)
        i2c_mode_pkg::ST_IDLE: begin
          if (accept) begin
            req_seen <= req_s;
            shreg    <= cmd_order ? i2c_mode_pkg::reverse8(cmd_data) : cmd_data;
            nbits    <= i2c_mode_pkg::frame_bits(!cmd_format && cmd_start, cmd_count);
            bit_idx  <= 4'h0;
            if (cmd_master && !cmd_format && cmd_start) begin
              state <= i2c_mode_pkg::ST_START;
            end else begin
              state <= i2c_mode_pkg::ST_BIT;
            end
          end
        end
        i2c_mode_pkg::ST_START: begin
          if (phase == `PH_SAMPLE) begin
            sda_level <= 1'b0;
          end
          if (wrap) begin
            state <= i2c_mode_pkg::ST_BIT;
          end
        end
        i2c_mode_pkg::ST_BIT: begin
          if (drv) begin
            sda_level <= cmd_recv || shreg[7];
          end
          if (smp) begin
            rxsh <= cmd_order ? {sda_s, rxsh[7:1]} : {rxsh[6:0], sda_s};
          end
          if (fin) begin
            shreg   <= {shreg[6:0], 1'b0};
            bit_idx <= bit_idx + 4'h1;
            if (last_bit) begin
              if (cmd_format) begin
                state <= i2c_mode_pkg::ST_DONE;
              end else if (eff_wait) begin
                state <= i2c_mode_pkg::ST_WAIT;
              end else begin
                state <= i2c_mode_pkg::ST_ACK;
              end
            end
          end
        end
        i2c_mode_pkg::ST_WAIT: begin
          if (wrap) begin
            if (wait_cnt == 3'(`WAIT_CLOCKS - 3'h1)) begin
              wait_cnt <= 3'h0;
              state    <= i2c_mode_pkg::ST_ACK;
            end else begin
              wait_cnt <= wait_cnt + 3'h1;
            end
          end
        end
        i2c_mode_pkg::ST_ACK: begin
          if (drv) begin
            sda_level <= cmd_recv ? cmd_ack : 1'b1;
          end
          if (smp) begin
            ack_rx <= sda_s;
          end
          if (fin) begin
            state <= (cmd_master && cmd_stop) ? i2c_mode_pkg::ST_STOP : i2c_mode_pkg::ST_DONE;
          end
        end
        i2c_mode_pkg::ST_STOP: begin
          if (phase == `PH_DRIVE) begin
            sda_level <= 1'b0;
          end
          if (wrap) begin
            sda_level <= 1'b1;
            state     <= i2c_mode_pkg::ST_DONE;
          end
        end
        i2c_mode_pkg::ST_DONE: begin
          rx_hold   <= rxsh;
          done_tgl  <= !done_tgl;
          sda_level <= 1'b1;
          state     <= i2c_mode_pkg::ST_IDLE;
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Checks

  AST_MON_READ: assert property (
    @(posedge clk) disable iff (!rst_n)
    (psel && !penable && !pwrite && paddr == `OFS_CTRL_TWO)
      |=> (prdata[`CT_MON_BIT] == $past(mon)))
    else $error("monitor bit read differs from synchronised SCL level");

  AST_CT_ONES: assert property (
    @(posedge clk) disable iff (!rst_n)
    (psel && !penable && !pwrite && paddr == `OFS_CTRL_TWO) |=> (prdata[2] && prdata[0]))
    else $error("control reserved bits not read as one");

  AST_RESET_KEEPS: assert property (
    @(posedge clk) disable iff (!rst_n)
    (ctl_reset && !wr) |=> ($stable(order) && $stable(wait_en) && $stable(format_sync)))
    else $error("control-part reset altered register contents");

  AST_RESET_IDLE: assert property (
    @(posedge link_clk) disable iff (!rst_n)
    rst_s |=> (state == i2c_mode_pkg::ST_IDLE && scl_level && sda_level))
    else $error("engine not idle and released during control-part reset");

  AST_ORDER_LOAD: assert property (
    @(posedge link_clk) disable iff (!rst_n || rst_s)
    accept |=> (shreg == (cmd_order ? i2c_mode_pkg::reverse8(cmd_data) : cmd_data)))
    else $error("shift register loaded in the wrong bit order");

  AST_WAIT_LEN: assert property (
    @(posedge link_clk) disable iff (!rst_n || rst_s)
    $rose(state == i2c_mode_pkg::ST_WAIT)
      |-> (state == i2c_mode_pkg::ST_WAIT && !scl_level)[*8] ##1 (state == i2c_mode_pkg::ST_ACK))
    else $error("wait did not hold SCL low for two transfer clocks");

  AST_NO_WAIT: assert property (
    @(posedge link_clk) disable iff (!rst_n || rst_s)
    ($past(state) == i2c_mode_pkg::ST_BIT && state != i2c_mode_pkg::ST_BIT && !cmd_wait)
      |-> (state == i2c_mode_pkg::ST_ACK || state == i2c_mode_pkg::ST_DONE))
    else $error("extra low period inserted with wait off");

  AST_WAIT_IGNORED: assert property (
    @(posedge link_clk) disable iff (!rst_n || rst_s)
    (state == i2c_mode_pkg::ST_WAIT) |-> (cmd_master && !cmd_format && cmd_wait))
    else $error("wait inserted as slave or in synchronous format");

  AST_BM_ONES: assert property (
    @(posedge clk) disable iff (!rst_n)
    (psel && !penable && !pwrite && paddr == `OFS_BUS_MODE) |=> (prdata[5:4] == 2'b11))
    else $error("bus mode reserved bits not read as one");

  AST_SYNC_NO_ACK: assert property (
    @(posedge link_clk) disable iff (!rst_n || rst_s)
    (state == i2c_mode_pkg::ST_ACK || state == i2c_mode_pkg::ST_START) |-> !cmd_format)
    else $error("two-wire phase used in synchronous format");

  AST_FIRST_FRAME: assert property (
    @(posedge link_clk) disable iff (!rst_n || rst_s)
    (accept && cmd_start && !cmd_format) |=> (nbits == `FIRST_FRAME_BITS))
    else $error("first frame after start is not eight bits");

  AST_FIXED_WRITE: assert property (
    @(posedge clk) disable iff (!rst_n)
    (wr && paddr == `OFS_CTRL_TWO) |=> (ctrl_word[2] && ctrl_word[0] && bm_word[5:4] == 2'b11))
    else $error("write disturbed fixed bits");

endmodule : i2c_mode_and_recovery_control

// [include/i2c_mode_regs.svh]
// Offsets, fields, reset values and timing counts of the mode and recovery control
// Notes on behaviour
// - Monitor bit shows driven SCL level.
// - Control bits 2 and 0 read 1.
// - Control-part reset clears engine, keeps registers.
// - Order bit: 0 MSB first, 1 LSB.
// - Master wait: SCL low two clocks pre-ack.
// - Without wait, data and ack back to back.
// - Wait ignored as slave or synchronous.
// - Bus mode bits 5 and 4 read 1.
// - Format bit picks two-wire or synchronous.
// - First two-wire frame after start: 8 bits.
`ifndef I2C_MODE_REGS_SVH
`define I2C_MODE_REGS_SVH

`define OFS_CTRL_TWO     12'h000
`define OFS_BUS_MODE     12'h004
`define OFS_SLV_ADDR     12'h008
`define OFS_XFER         12'h00C

`define CT_RST_BIT       1
`define CT_MON_BIT       3
`define CT_FIXED_ONES    8'h05

`define BM_ORDER_BIT     7
`define BM_WAIT_BIT      6
`define BM_COUNT_LSB     0
`define BM_FIXED_ONES    8'h30

`define SA_FORMAT_BIT    0
`define SA_ADDR_LSB      1

`define XF_DATA_LSB      0
`define XF_START_BIT     8
`define XF_STOP_BIT      9
`define XF_RECV_BIT      10
`define XF_MASTER_BIT    11
`define XF_ACK_BIT       12
`define XF_BUSY_BIT      16
`define XF_ACKIN_BIT     17

`define RST_CTRL_RESET   1'b0
`define RST_ORDER        1'b0
`define RST_WAIT         1'b0
`define RST_COUNT        3'h0
`define RST_FORMAT       1'b0
`define RST_SLV_ADDR     7'h00

`define FIRST_FRAME_BITS 4'h8
`define WAIT_CLOCKS      3'h2
`define PH_DRIVE         2'h0
`define PH_SAMPLE        2'h2
`define PH_LAST          2'h3

`endif

// [include/i2c_mode_pkg.sv]
// Types and helper functions shared by the mode and recovery control
`include "i2c_mode_regs.svh"
package i2c_mode_pkg;

  typedef enum logic [2:0] {
    ST_IDLE, ST_START, ST_BIT, ST_WAIT, ST_ACK, ST_STOP, ST_DONE
  } eng_state_t;

  typedef logic [7:0] octet_t;

  function automatic octet_t reverse8(input octet_t v);
    octet_t r;
    r = 8'h00;
    for (int i = 0; i < 8; i++) begin
      r[i] = v[7 - i];
    end
    return r;
  endfunction : reverse8

  // A count field of zero stands for a full eight-bit frame
  function automatic logic [3:0] frame_bits(input logic first_frame, input logic [2:0] count);
    return (first_frame || count == 3'h0) ? `FIRST_FRAME_BITS : {1'b0, count};
  endfunction : frame_bits

endpackage : i2c_mode_pkg

// [core/level_sync.sv]
// Two-flop synchroniser for a single level
`timescale 1ns/100ps
module level_sync #(
  parameter logic RST_VAL = 1'b0
) (
  input  wire logic clk,
  input  wire logic rst_n,
  input  wire logic d,
  output logic      q
);

  logic meta;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      meta <= RST_VAL;
      q    <= RST_VAL;
    end else begin
      meta <= d;
      q    <= meta;
    end
  end

endmodule : level_sync

// [core/phase_gen.sv]
// Four-phase transfer clock sequencer on the link clock
`timescale 1ns/100ps
`include "i2c_mode_regs.svh"
module phase_gen (
  input  wire logic       clk,
  input  wire logic       rst_n,
  input  wire logic       run,
  output logic [1:0]      phase,
  output logic            wrap
);

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      phase <= 2'h0;
    end else if (!run) begin
      phase <= 2'h0;
    end else begin
      phase <= phase + 2'h1;
    end
  end

  assign wrap = run && (phase == `PH_LAST);

endmodule : phase_gen

// [tb/i2c_bus_partner.sv]
// Behavioural slave on the two-wire bus: captures bytes, acks, sends data, times SCL lows
`timescale 1ns/100ps
module i2c_bus_partner (
  input  wire logic       link_clk,
  input  wire logic       rst_n,
  input  wire logic       scl,
  input  wire logic       sda,
  input  wire logic       clr,
  input  wire logic       ack_en,
  input  wire logic       send,
  input  wire logic [7:0] tx_byte,
  output logic            sda_oe_n,
  output logic      [7:0] rx_byte,
  output logic      [4:0] bits,
  output logic      [4:0] low_max
);
  logic       scl_q;
  logic       sda_q;
  logic [4:0] low_run;

  ////////////////////////////////////////////////////////////////////////////////
  always_ff @(posedge link_clk or negedge rst_n) begin
    if (!rst_n) begin
      scl_q    <= 1'b1;
      sda_q    <= 1'b1;
      bits     <= 5'h00;
      low_max  <= 5'h00;
      low_run  <= 5'h00;
      rx_byte  <= 8'h00;
      sda_oe_n <= 1'b1;
    end else begin
      scl_q <= scl;
      sda_q <= sda;
      // Start condition restarts the bit count like a real slave would
      if (clr || (scl && scl_q && sda_q && !sda)) begin
        bits    <= 5'h00;
        low_max <= 5'h00;
        low_run <= 5'h00;
      end else if (scl && !scl_q) begin
        bits <= bits + 5'h01;
        if (bits < 5'h08) rx_byte <= {rx_byte[6:0], sda};
        if (low_run > low_max) low_max <= low_run;
        low_run <= 5'h00;
      end else if (!scl) begin
        low_run <= low_run + 5'h01;
      end
      // Data and ack change only while SCL is low
      if (!scl && scl_q) begin
        if (send && bits < 5'h08) sda_oe_n <= tx_byte[3'h7 - bits[2:0]];
        else if (bits == 5'h08) sda_oe_n <= !ack_en;
        else sda_oe_n <= 1'b1;
      end
    end
  end
endmodule : i2c_bus_partner

// [tb/i2c_mode_and_recovery_control_tb_top.sv]
// Register-level tests of the mode and recovery control against a bus partner
`timescale 1ns/100ps
`include "i2c_mode_regs.svh"
module i2c_mode_and_recovery_control_tb_top;
  logic        clk;
  logic        link_clk;
  logic        rst_n;
  logic        psel;
  logic        penable;
  logic        pwrite;
  logic [11:0] paddr;
  logic [31:0] pwdata;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic        scl_oe_n;
  logic        sda_oe_n;
  logic        p_sda_oe_n;
  logic        clr;
  logic        ack_en;
  logic        send;
  logic [7:0]  tx_byte;
  logic [7:0]  rx_byte;
  logic [4:0]  bits;
  logic [4:0]  low_max;
  logic        mon_low;
  logic [31:0] rd;
  logic        err;
  int          error_cnt;
  int          compares;
  // Open-drain wires with pull-ups: low only while some party drives
  wire scl_w = scl_oe_n;
  wire sda_w = sda_oe_n & p_sda_oe_n;

  i2c_mode_and_recovery_control i_dut (
    .clk(clk), .rst_n(rst_n), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .link_clk(link_clk), .scl_in(scl_w), .scl_out(), .scl_oe_n(scl_oe_n),
    .sda_in(sda_w), .sda_out(), .sda_oe_n(sda_oe_n)
  );
  i2c_bus_partner i_partner (
    .link_clk(link_clk), .rst_n(rst_n), .scl(scl_w), .sda(sda_w), .clr(clr),
    .ack_en(ack_en), .send(send), .tx_byte(tx_byte), .sda_oe_n(p_sda_oe_n),
    .rx_byte(rx_byte), .bits(bits), .low_max(low_max)
  );

  always #10 clk = ~clk;
  always #24 link_clk = ~link_clk;

  ////////////////////////////////////////////////////////////////////////////////
  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      error_cnt++;
      $display("[FAIL] %s expected %h seen %h", name, exp, seen);
    end
  endtask : check

  task automatic apb(input logic [11:0] a, input logic w, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge clk);
    penable <= 1'b1;
    @(posedge clk);
    while (pready !== 1'b1 && n < 50) begin
      n++;
      @(posedge clk);
    end
    if (n >= 50) error_cnt++;
    rd = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic rd_chk(input string name, input logic [11:0] a, input logic [31:0] exp);
    apb(a, 1'b0, 32'h0000_0000);
    check(name, rd, exp);
  endtask : rd_chk

  // Polls busy; the monitor bit is sampled in between to catch a driven-low SCL
  task automatic run_xfer(input logic do_clr, input logic [31:0] w);
    int n;
    n = 0;
    if (do_clr) begin
      clr <= 1'b1;
      repeat (6) @(posedge clk);
      clr <= 1'b0;
    end
    mon_low = 1'b0;
    apb(`OFS_XFER, 1'b1, w);
    do begin
      apb(`OFS_CTRL_TWO, 1'b0, 32'h0);
      if (rd[`CT_MON_BIT] === 1'b0) mon_low = 1'b1;
      apb(`OFS_XFER, 1'b0, 32'h0);
      n++;
    end while (rd[`XF_BUSY_BIT] !== 1'b0 && n < 2000);
    if (n >= 2000) error_cnt++;
    repeat (10) @(posedge clk);
  endtask : run_xfer

  task automatic test_end(input string name);
    $display("test %s done, mismatches so far %0d", name, error_cnt);
  endtask : test_end

  task automatic wrap_up;
    $display("compares %0d error_cnt %0d", compares, error_cnt);
    if (error_cnt == 0 && compares > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : wrap_up

  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    clk = 1'b0; link_clk = 1'b0; rst_n = 1'b0; psel = 1'b0; penable = 1'b0;
    pwrite = 1'b0; paddr = 12'h000; pwdata = 32'h0; clr = 1'b0; ack_en = 1'b1;
    send = 1'b0; tx_byte = 8'h00; error_cnt = 0; compares = 0; mon_low = 1'b0;
    repeat (5) @(posedge clk);
    rst_n <= 1'b1;
    rd_chk("ctrl reset", `OFS_CTRL_TWO, 32'h0000_000D);
    rd_chk("mode reset", `OFS_BUS_MODE, 32'h0000_0030);
    rd_chk("addr reset", `OFS_SLV_ADDR, 32'h0000_0000);
    apb(12'h010, 1'b0, 32'h0);
    check("unmapped err", err, 32'h1);
    check("unmapped data", rd, 32'h0);
    test_end("reset");
    apb(`OFS_BUS_MODE, 1'b1, 32'h0000_00FF);
    rd_chk("mode ones", `OFS_BUS_MODE, 32'h0000_00F7);
    apb(`OFS_BUS_MODE, 1'b1, 32'h0000_0000);
    rd_chk("mode zeros", `OFS_BUS_MODE, 32'h0000_0030);
    apb(`OFS_CTRL_TWO, 1'b1, 32'h0000_00FF);
    rd_chk("ctrl ones", `OFS_CTRL_TWO, 32'h0000_000F);
    apb(`OFS_CTRL_TWO, 1'b1, 32'h0000_0000);
    rd_chk("ctrl zeros", `OFS_CTRL_TWO, 32'h0000_000D);
    test_end("access");
    // Two-wire transfers keep MSB first
    apb(`OFS_BUS_MODE, 1'b1, 32'h0000_0000);
    run_xfer(1'b1, 32'h0000_0B55);
    check("tx byte", rx_byte, 8'h55);
    // Clock counts include the SCL rise that opens the stop condition
    check("tx bits", bits, 5'h0A);
    check("no wait low", low_max, 5'h02);
    check("monitor low", mon_low, 1'b1);
    check("ack seen", rd[`XF_ACKIN_BIT], 1'b0);
    test_end("master tx");
    ack_en <= 1'b0;
    apb(`OFS_BUS_MODE, 1'b1, 32'h0000_0040);
    run_xfer(1'b1, 32'h0000_0BC3);
    check("wait byte", rx_byte, 8'hC3);
    check("wait low", low_max, 5'h0A);
    check("nack seen", rd[`XF_ACKIN_BIT], 1'b1);
    test_end("wait");
    send <= 1'b1;
    tx_byte <= 8'hA6;
    apb(`OFS_BUS_MODE, 1'b1, 32'h0000_0000);
    run_xfer(1'b1, 32'h0000_1F00);
    check("rx byte", rd[7:0], 8'hA6);
    check("rx bits", bits, 5'h0A);
    send <= 1'b0;
    test_end("master rx");
    apb(`OFS_BUS_MODE, 1'b1, 32'h0000_0003);
    run_xfer(1'b1, 32'h0000_0900);
    check("first frame", bits, 5'h09);
    run_xfer(1'b0, 32'h0000_0A00);
    check("next frame", bits, 5'h0E);
    test_end("frame length");
    // Clocked synchronous format: LSB first, wait must have no effect
    apb(`OFS_SLV_ADDR, 1'b1, 32'h0000_0001);
    apb(`OFS_BUS_MODE, 1'b1, 32'h0000_00C0);
    run_xfer(1'b1, 32'h0000_0801);
    check("sync byte", rx_byte, 8'h80);
    check("sync bits", bits, 5'h08);
    check("sync low", low_max, 5'h02);
    apb(`OFS_SLV_ADDR, 1'b1, 32'h0000_0000);
    test_end("sync");
    apb(`OFS_BUS_MODE, 1'b1, 32'h0000_0043);
    apb(`OFS_XFER, 1'b1, 32'h0000_0BFF);
    repeat (60) @(posedge clk);
    apb(`OFS_CTRL_TWO, 1'b1, 32'h0000_0002);
    repeat (20) @(posedge clk);
    check("scl freed", scl_oe_n, 1'b1);
    check("sda freed", sda_oe_n, 1'b1);
    apb(`OFS_XFER, 1'b0, 32'h0);
    check("busy cleared", rd[`XF_BUSY_BIT], 1'b0);
    rd_chk("mode kept", `OFS_BUS_MODE, 32'h0000_0073);
    rd_chk("ctrl set", `OFS_CTRL_TWO, 32'h0000_000F);
    apb(`OFS_CTRL_TWO, 1'b1, 32'h0000_0000);
    ack_en <= 1'b1;
    run_xfer(1'b1, 32'h0000_0B3C);
    check("after reset", rx_byte, 8'h3C);
    test_end("recovery");
    wrap_up();
  end

  initial begin
    repeat (90000) @(posedge clk);
    error_cnt++;
    wrap_up();
  end
endmodule : i2c_mode_and_recovery_control_tb_top
